// ==== hdl/sbt_consts.svh ====
// constants shared by the burst serial target port
`ifndef SBT_CONSTS_SVH
`define SBT_CONSTS_SVH
`define SBT_INSTR_BITS 16
`define SBT_ADDR_W 15
`define SBT_DATA_W 8
`define SBT_WORD_W 23
`define SBT_CNT_W 4
`define SBT_INSTR_LAST 4'hf
`define SBT_BYTE_LAST 4'h7
`define SBT_RW_BIT 15
`define SBT_ADDR_ZERO 15'h0000
`define SBT_LAST_ADDR 15'h0fff
`define SBT_FIFO_DEPTH 32
`define SBT_PTR_W 5
`endif

// ==== hdl/sbt_pkg.sv ====
// types for the burst serial target port
`default_nettype none
package sbt_pkg;
   typedef enum logic [2:0] {
      SBT_IDLE,
      SBT_INSTR,
      SBT_WRITE,
      SBT_READ,
      SBT_DONE
   } sbt_state_type;
endpackage : sbt_pkg
`default_nettype wire

// ==== hdl/sbt_stream_if.sv ====
// valid/ready word stream between the port and its fifo
`default_nettype none
interface sbt_stream_if #(parameter int WIDTH = 8);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : sbt_stream_if
`default_nettype wire

// ==== hdl/sbt_sync.sv ====
// three-stage input synchroniser with agreement filter
`default_nettype none
module sbt_sync (
   input wire logic clk,
   input wire logic nrst,
   input wire logic async_in,
   output var logic sync_out
);
   logic s1_reg, s2_reg, s3_reg, out_reg;
   logic out_next;

   // a change counts only once stages two and three agree
   always_comb begin
      out_next = out_reg;
      if (s2_reg == s3_reg) begin
         out_next = s3_reg;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         out_reg <= 1'b0;
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         out_reg <= out_next;
      end
   end

   assign sync_out = out_reg;
endmodule : sbt_sync
`default_nettype wire

// ==== hdl/sbt_fifo.sv ====
// flip-flop fifo with valid/ready on both sides
`default_nettype none
module sbt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32,
   parameter int PTR_W = 5
) (
   input wire logic clk,
   input wire logic nrst,
   sbt_stream_if.snk in_s,
   sbt_stream_if.src out_s
);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
   logic [PTR_W:0] cnt_reg, cnt_next;
   logic do_push, do_pop;

   // honest full and empty from the fill count
   always_comb begin
      do_push = in_s.valid && (cnt_reg != (PTR_W+1)'(DEPTH));
      do_pop = out_s.ready && (cnt_reg != '0);
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      cnt_next = cnt_reg;
      if (do_push) begin
         wr_ptr_next = (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 :
                       wr_ptr_reg + PTR_W'(1);
      end
      if (do_pop) begin
         rd_ptr_next = (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 :
                       rd_ptr_reg + PTR_W'(1);
      end
      if (do_push && !do_pop) begin
         cnt_next = cnt_reg + (PTR_W+1)'(1);
      end else if (do_pop && !do_push) begin
         cnt_next = cnt_reg - (PTR_W+1)'(1);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         cnt_reg <= cnt_next;
      end
   end

   // storage needs no reset, reads are gated by valid
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_reg[wr_ptr_reg] <= in_s.data;
      end
   end

   assign in_s.ready = (cnt_reg != (PTR_W+1)'(DEPTH));
   assign out_s.valid = (cnt_reg != '0);
   assign out_s.data = mem_reg[rd_ptr_reg];
endmodule : sbt_fifo
`default_nettype wire

// ==== hdl/sbt_spi_burst.sv ====
// burst serial target port: framing, address stepping, read/write paths
// Behaviour
// - burst on: keep moving bytes while selected
// - step up adds one, last wraps to zero
// - step down subtracts one, zero wraps to last
// - low-first: address low bit first, then direction
// - write: step address after eighth bit
// - read: shift byte out, step, keep sending
// - high-first: direction, address high first, data
// - bit order setting applies to instruction and data
// - wiring setting one selects separate output line
// - three-wire returns read data on data line
// - bits captured on serial clock rising edge
// - bits launched on serial clock falling edge
// - select high aborts, completed bytes stay valid
// - deselected: ignore clock, release both lines
// - undefined address: drop write, read zeros
`default_nettype none
`include "sbt_consts.svh"
module sbt_spi_burst
   import sbt_pkg::*;
#(
   parameter logic [`SBT_ADDR_W-1:0] LAST_REG_ADDR = `SBT_LAST_ADDR
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic chip_select_n,
   input wire logic sclk,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic serial_data_out,
   output logic serial_data_out_oe,
   input wire logic burst_enable,
   input wire logic address_step_up,
   input wire logic separate_output_line_select,
   input wire logic high_bit_first,
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [`SBT_ADDR_W-1:0] wr_addr,
   output logic [`SBT_DATA_W-1:0] wr_data,
   output logic rd_strobe,
   output logic [`SBT_ADDR_W-1:0] rd_addr,
   input wire logic [`SBT_DATA_W-1:0] rd_data,
   output logic overflow
);
   ////////////////////////////////////////////////////////////////////////
   logic csn_f, sclk_f, sdio_f, sel_f;

   // pins are from another domain, filter each one
   // select filtered active high: the reset state then reads as deselected,
   // so no false frame opens while the pipe fills after reset
   sbt_sync u_sync_cs (.clk(clk), .nrst(nrst), .async_in(!chip_select_n),
      .sync_out(sel_f));
   assign csn_f = !sel_f;
   sbt_sync u_sync_clk (.clk(clk), .nrst(nrst), .async_in(sclk),
      .sync_out(sclk_f));
   sbt_sync u_sync_dio (.clk(clk), .nrst(nrst), .async_in(sdio_in),
      .sync_out(sdio_f));

   ////////////////////////////////////////////////////////////////////////
   sbt_stream_if #(.WIDTH(`SBT_WORD_W)) push_s ();
   sbt_stream_if #(.WIDTH(`SBT_WORD_W)) pop_s ();

   // the port cannot stall the master, so a full fifo drops bytes
   sbt_fifo #(.WIDTH(`SBT_WORD_W), .DEPTH(`SBT_FIFO_DEPTH),
      .PTR_W(`SBT_PTR_W)) u_fifo (.clk(clk), .nrst(nrst),
      .in_s(push_s.snk), .out_s(pop_s.src));

   assign wr_valid = pop_s.valid;
   assign pop_s.ready = wr_ready;
   assign wr_addr = pop_s.data[`SBT_WORD_W-1:`SBT_DATA_W];
   assign wr_data = pop_s.data[`SBT_DATA_W-1:0];

   ////////////////////////////////////////////////////////////////////////
   sbt_state_type state_reg, state_next;
   logic [`SBT_CNT_W-1:0] bit_cnt_reg, bit_cnt_next;
   logic [`SBT_INSTR_BITS-1:0] instr_reg, instr_next;
   logic [`SBT_ADDR_W-1:0] addr_reg, addr_next;
   logic [`SBT_DATA_W-1:0] rx_reg, rx_next, tx_reg, tx_next;
   logic out_bit_reg, out_bit_next, oe_reg, oe_next;
   logic strobe_reg, strobe_next, ovf_reg, ovf_next;
   logic sclk_prev_reg;
   logic rise, fall, push, addr_defined;
   logic [`SBT_INSTR_BITS-1:0] instr_new;
   logic [`SBT_DATA_W-1:0] rx_new;
   logic [`SBT_ADDR_W-1:0] addr_step;

   assign rise = sclk_f && !sclk_prev_reg;
   assign fall = !sclk_f && sclk_prev_reg;
   assign addr_defined = (addr_reg <= LAST_REG_ADDR);

   // next address with wrap at both ends of the map
   always_comb begin
      if (address_step_up) begin
         addr_step = (addr_reg == LAST_REG_ADDR) ? `SBT_ADDR_ZERO :
                     addr_reg + 15'h0001;
      end else begin
         addr_step = (addr_reg == `SBT_ADDR_ZERO) ? LAST_REG_ADDR :
                     addr_reg - 15'h0001;
      end
   end

   // one layout for both orders: rw lands in bit 15, address below
   always_comb begin
      if (high_bit_first) begin
         instr_new = {instr_reg[`SBT_INSTR_BITS-2:0], sdio_f};
         rx_new = {rx_reg[`SBT_DATA_W-2:0], sdio_f};
      end else begin
         instr_new = {sdio_f, instr_reg[`SBT_INSTR_BITS-1:1]};
         rx_new = {sdio_f, rx_reg[`SBT_DATA_W-1:1]};
      end
   end

   // main sequencer
   always_comb begin
      state_next = state_reg;
      bit_cnt_next = bit_cnt_reg;
      instr_next = instr_reg;
      addr_next = addr_reg;
      rx_next = rx_reg;
      tx_next = tx_reg;
      out_bit_next = out_bit_reg;
      oe_next = oe_reg;
      strobe_next = 1'b0;
      ovf_next = ovf_reg;
      push = 1'b0;
      // fetched data arrives the cycle after the strobe
      if (strobe_reg) begin
         tx_next = addr_defined ? rd_data : 8'h00;
      end
      if (csn_f) begin
         // deselect ignores the clock and aborts any partial byte
         state_next = SBT_IDLE;
         bit_cnt_next = '0;
         oe_next = 1'b0;
      end else begin
         case (state_reg)
            SBT_IDLE, SBT_INSTR: begin
               if (state_reg == SBT_IDLE) begin
                  ovf_next = 1'b0;
                  state_next = SBT_INSTR;
               end
               if (rise) begin
                  instr_next = instr_new;
                  bit_cnt_next = bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == `SBT_INSTR_LAST) begin
                     bit_cnt_next = '0;
                     addr_next = instr_new[`SBT_ADDR_W-1:0];
                     if (instr_new[`SBT_RW_BIT]) begin
                        state_next = SBT_READ;
                        strobe_next = 1'b1;
                        oe_next = 1'b1;
                     end else begin
                        state_next = SBT_WRITE;
                     end
                  end
               end
            end
            SBT_WRITE: begin
               if (rise) begin
                  rx_next = rx_new;
                  bit_cnt_next = bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == `SBT_BYTE_LAST) begin
                     bit_cnt_next = '0;
                     addr_next = addr_step;
                     if (addr_defined) begin
                        push = push_s.ready;
                        ovf_next = ovf_reg || !push_s.ready;
                     end
                     if (!burst_enable) begin
                        state_next = SBT_DONE;
                     end
                  end
               end
            end
            SBT_READ: begin
               if (fall) begin
                  out_bit_next = high_bit_first ? tx_reg[`SBT_DATA_W-1] :
                                 tx_reg[0];
               end
               if (rise) begin
                  tx_next = high_bit_first ?
                            {tx_reg[`SBT_DATA_W-2:0], 1'b0} :
                            {1'b0, tx_reg[`SBT_DATA_W-1:1]};
                  bit_cnt_next = bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == `SBT_BYTE_LAST) begin
                     bit_cnt_next = '0;
                     addr_next = addr_step;
                     if (burst_enable) begin
                        strobe_next = 1'b1;
                     end else begin
                        state_next = SBT_DONE;
                     end
                  end
               end
            end
            SBT_DONE: begin
               // single-byte access over, wait for deselect
               state_next = SBT_DONE;
            end
            default: begin
               state_next = SBT_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= SBT_IDLE;
         bit_cnt_reg <= '0;
         instr_reg <= '0;
         addr_reg <= '0;
         rx_reg <= '0;
         tx_reg <= '0;
         out_bit_reg <= 1'b0;
         oe_reg <= 1'b0;
         strobe_reg <= 1'b0;
         ovf_reg <= 1'b0;
         sclk_prev_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         instr_reg <= instr_next;
         addr_reg <= addr_next;
         rx_reg <= rx_next;
         tx_reg <= tx_next;
         out_bit_reg <= out_bit_next;
         oe_reg <= oe_next;
         strobe_reg <= strobe_next;
         ovf_reg <= ovf_next;
         sclk_prev_reg <= sclk_f;
      end
   end

   // written byte carries the address it was aimed at
   assign push_s.valid = push;
   assign push_s.data = {addr_reg, rx_new};

   ////////////////////////////////////////////////////////////////////////
   // read data goes to one line only, chosen by the wiring setting
   assign sdio_out = out_bit_reg;
   assign sdio_oe = oe_reg && !separate_output_line_select;
   assign serial_data_out = out_bit_reg;
   assign serial_data_out_oe = oe_reg &&
      separate_output_line_select;
   assign rd_strobe = strobe_reg;
   assign rd_addr = addr_reg;
   assign overflow = ovf_reg;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence seq_wr_byte_end;
      !csn_f && state_reg == SBT_WRITE && rise &&
      bit_cnt_reg == `SBT_BYTE_LAST;
   endsequence

   sequence seq_rd_byte_end;
      !csn_f && state_reg == SBT_READ && rise &&
      bit_cnt_reg == `SBT_BYTE_LAST;
   endsequence

   sequence seq_instr_read;
      !csn_f && state_reg == SBT_INSTR && rise &&
      bit_cnt_reg == `SBT_INSTR_LAST && instr_new[`SBT_RW_BIT];
   endsequence

   a_burst_continues: assert property (seq_wr_byte_end ##0 burst_enable
      |=> state_reg == SBT_WRITE)
      else $error("burst write stopped early");
   a_single_stops: assert property (seq_rd_byte_end ##0 !burst_enable
      |=> state_reg == SBT_DONE && !strobe_reg)
      else $error("single read did not stop");
   a_wrap_up: assert property (seq_wr_byte_end ##0 address_step_up
      ##0 addr_reg == LAST_REG_ADDR |=> addr_reg == 15'h0000)
      else $error("increment did not wrap to zero");
   a_step_down: assert property (seq_wr_byte_end ##0 !address_step_up
      |=> addr_reg == (($past(addr_reg) == 15'h0000) ? LAST_REG_ADDR :
      $past(addr_reg) - 15'h0001))
      else $error("decrement step wrong");
   a_step_up_one: assert property (seq_wr_byte_end ##0 address_step_up
      ##0 addr_reg != LAST_REG_ADDR
      |=> addr_reg == $past(addr_reg) + 15'h0001)
      else $error("increment step wrong");
   a_read_refetch: assert property (seq_rd_byte_end ##0 burst_enable
      |=> strobe_reg ##1 tx_reg == (addr_defined ? $past(rd_data) :
      8'h00))
      else $error("next read byte not fetched");
   a_undef_write_drop: assert property (push_s.valid
      |-> addr_reg <= LAST_REG_ADDR)
      else $error("write to undefined address pushed");
   a_deselect_release: assert property (csn_f
      |=> !sdio_oe && !serial_data_out_oe && state_reg == SBT_IDLE)
      else $error("lines driven while deselected");
   a_drive_after_instr: assert property (seq_instr_read
      |=> oe_reg && state_reg == SBT_READ)
      else $error("read drive not started after instruction");
   a_no_early_drive: assert property ($rose(oe_reg)
      |-> $past(state_reg) == SBT_INSTR)
      else $error("drive began before instruction end");
   a_line_select: assert property (oe_reg |-> (sdio_oe ^
      serial_data_out_oe) && (serial_data_out_oe ==
      separate_output_line_select))
      else $error("wrong output line driven");
   a_fresh_frame: assert property ($fell(csn_f)
      |-> bit_cnt_reg == '0 && state_reg == SBT_IDLE)
      else $error("frame did not start fresh");
endmodule : sbt_spi_burst
`default_nettype wire

// ==== testbench/sbt_spi_master.sv ====
// serial bus master model for the burst target port
`default_nettype none
module sbt_spi_master (
   output logic csn,
   output logic sclk,
   output logic mosi,
   output logic mosi_en,
   output logic instr_phase,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] tx_q[$];
   logic [7:0] rx_q[$];
   // idle: deselected, clock parked low between frames
   initial begin
      csn = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
      mosi_en = 1'b1;
      instr_phase = 1'b0;
   end
   // nbits short of 16 + 8n cuts the frame mid-way (abort)
   task automatic run(input logic msb, input logic rw,
                      input logic [14:0] a, input int nbits);
      logic [15:0] ins;
      logic [7:0] b;
      logic [7:0] r;
      int j;
      ins = {rw, a};
      #1.3;
      csn = 1'b0;
      instr_phase = 1'b1;
      #40;
      for (int i = 0; i < nbits; i++) begin
         j = (i - 16) % 8;
         if (i >= 16 && j == 0 && !rw) b = tx_q.pop_front();
         // released in read data phase so the target can turn the line
         mosi_en = !(rw && i >= 16);
         mosi = (i < 16) ? (msb ? ins[15-i] : ins[i]) :
            (msb ? b[7-j] : b[j]);
         #40;
         sclk = 1'b1;
         if (i == 15) instr_phase = 1'b0;
         if (i >= 16 && rw) r[msb ? 7-j : j] = miso;
         if (i >= 16 && rw && j == 7) rx_q.push_back(r);
         #40;
         sclk = 1'b0;
      end
      #40;
      csn = 1'b1;
      mosi_en = 1'b1;
      instr_phase = 1'b0;
      #200;
   endtask
endmodule // sbt_spi_master
`default_nettype wire

// ==== testbench/sbt_spi_burst_tb.sv ====
// self-checking bench for the burst serial target port
`default_nettype none
module sbt_spi_burst_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [14:0] LAST = 15'h0fff;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic burst_enable = 1'b1;
   logic address_step_up = 1'b1;
   logic separate_output_line_select = 1'b1;
   logic high_bit_first = 1'b1;
   logic wr_ready = 1'b0;
   logic stall = 1'b0;
   logic tgl = 1'b0;
   logic [2:0] cnt = 3'h0;
   logic [7:0] rd_data;
   logic csn, sclk, mosi, mosi_en, instr_phase, miso, sdio_line, sdo_line;
   logic sdio_out, sdio_oe, serial_data_out, serial_data_out_oe;
   logic wr_valid, rd_strobe, overflow;
   logic [14:0] wr_addr, rd_addr;
   logic [7:0] wr_data;
   logic [31:0] seed = 32'h647183c4;
   logic [22:0] got_q[$];
   logic [22:0] exp_q[$];
   int n_errors = 0;
   int samples_checked = 0;
   logic zero_written = 1'b0;
   int n_strobe = 0;

   ////////////////////////////////////////////////////////////////////////
   // clock and a line pattern for undriven wires (never a stale level)
   always #2.5 clk = ~clk;
   always @(posedge clk) tgl <= ~tgl;
   // sink stalls two cycles in eight, or fully while filling the fifo
   always @(posedge clk) begin
      #1;
      cnt <= cnt + 3'h1;
      wr_ready <= !stall && cnt[2:1] != 2'b11;
   end
   // register map behind the read port
   always_comb rd_data = rd_addr[7:0] ^ 8'ha5;
   assign sdio_line = sdio_oe ? sdio_out : (mosi_en ? mosi : tgl);
   assign sdo_line = serial_data_out_oe ? serial_data_out : tgl;
   assign miso = separate_output_line_select ? sdo_line : sdio_line;
   // words leaving the fifo
   always @(posedge clk) begin
      if (wr_valid === 1'b1 && wr_ready) got_q.push_back({wr_addr, wr_data});
   end
   // read fetches requested towards the register map
   always @(posedge clk) begin
      if (rd_strobe === 1'b1) n_strobe++;
   end
   // no drive on either data line while the instruction is coming in
   always @(posedge clk) begin
      if (instr_phase && (sdio_oe | serial_data_out_oe) === 1'b1) begin
         n_errors++;
         $display("MISMATCH oe_in_instr expected 0 seen 1");
      end
   end

   sbt_spi_master m (.csn(csn), .sclk(sclk), .mosi(mosi),
      .mosi_en(mosi_en), .instr_phase(instr_phase), .miso(miso));

   sbt_spi_burst #(.LAST_REG_ADDR(LAST)) dut (.clk(clk), .nrst(nrst),
      .chip_select_n(csn), .sclk(sclk), .sdio_in(sdio_line),
      .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .serial_data_out(serial_data_out),
      .serial_data_out_oe(serial_data_out_oe),
      .burst_enable(burst_enable), .address_step_up(address_step_up),
      .separate_output_line_select(separate_output_line_select),
      .high_bit_first(high_bit_first), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data),
      .overflow(overflow));

   ////////////////////////////////////////////////////////////////////////
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [14:0] step(input logic [14:0] a, input logic up);
      if (up) return (a == LAST) ? 15'h0000 : a + 15'h0001;
      return (a == 15'h0000) ? LAST : a - 15'h0001;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cfg(input logic [3:0] c);
      {burst_enable, address_step_up, separate_output_line_select,
         high_bit_first} = c;
   endtask

   // one frame: model the expected words, run it, compare
   task automatic frame(input logic rw, input logic [14:0] a, input int nb,
                        input int cut);
      logic [14:0] p;
      logic [31:0] r;
      int nbits;
      int k;
      logic hz;
      p = a;
      hz = 1'b0;
      // address zero configures the port: written once only, at start-up
      for (int i = 0; i < nb; i++) begin
         if (p == 15'h0000 && (burst_enable || i == 0)) hz = 1'b1;
         p = step(p, address_step_up);
      end
      if (!rw && hz && zero_written) rw = 1'b1;
      if (!rw && hz) zero_written = 1'b1;
      p = a;
      nbits = 16 + 8 * nb - cut;
      k = (nbits < 16) ? 0 : (nbits - 16) / 8;
      got_q.delete();
      exp_q.delete();
      m.rx_q.delete();
      n_strobe = 0;
      for (int i = 0; i < nb; i++) begin
         r = rnd();
         m.tx_q.push_back(r[7:0]);
         if (i < k && (burst_enable || i == 0)) begin
            if (rw) exp_q.push_back({p, (p <= LAST) ? p[7:0] ^ 8'ha5 : 8'h00});
            else if (p <= LAST) exp_q.push_back({p, r[7:0]});
         end
         p = step(p, address_step_up);
      end
      m.run(high_bit_first, rw, a, nbits);
      m.tx_q.delete();
      if (stall) begin
         chk("overflow_set", 1, overflow);
         while (exp_q.size() > 32) void'(exp_q.pop_back());
         stall = 1'b0;
      end else begin
         chk("overflow_clr", 0, overflow);
      end
      for (int t = 0; t < 400 && wr_valid !== 1'b0; t++) @(posedge clk);
      repeat (4) @(posedge clk);
      chk("oe_idle", 0, {sdio_oe, serial_data_out_oe});
      chk("write_count", rw ? 0 : exp_q.size(), got_q.size());
      chk("strobe_count", (!rw || nbits < 16) ? 0 :
         (burst_enable ? 1 + k : 1), n_strobe);
      for (int i = 0; i < exp_q.size(); i++) begin
         if (rw) chk("read_byte", exp_q[i][7:0], m.rx_q[i]);
         else chk("write_word", exp_q[i], got_q[i]);
      end
      #1;
   endtask

   task automatic end_sim();
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // hang guard, well past the expected run length
   initial begin
      #400us;
      n_errors++;
      end_sim();
   end

   // corner cases, then random frames
   initial begin
      logic [31:0] r;
      logic [14:0] a;
      repeat (20) @(posedge clk);
      #1;
      nrst = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      cfg(4'b1100);
      frame(0, LAST - 15'h0001, 4, 0);
      cfg(4'b1011);
      frame(0, 15'h0005, 4, 0);
      cfg(4'b1111);
      frame(1, LAST - 15'h0001, 3, 0);
      cfg(4'b1000);
      frame(1, 15'h0001, 3, 0);
      cfg(4'b1110);
      frame(0, 15'h0010, 3, 4);
      frame(0, 15'h0020, 1, 20);
      frame(0, 15'h0024, 2, 0);
      frame(0, 15'h1000, 2, 0);
      frame(1, 15'h1000, 2, 0);
      cfg(4'b0110);
      frame(0, 15'h0030, 3, 0);
      frame(1, 15'h0030, 2, 0);
      cfg(4'b1101);
      stall = 1'b1;
      frame(0, 15'h0100, 34, 0);
      frame(0, 15'h0200, 1, 0);
      for (int n = 0; n < 14; n++) begin
         r = rnd();
         cfg(r[3:0]);
         a = (r[5:4] == 2'h0) ? 15'h0000 : (r[5:4] == 2'h1) ? LAST :
            (r[5:4] == 2'h2) ? LAST + 15'h0001 : {3'h0, r[17:6]};
         frame(r[18], a, 1 + r[20:19], r[21] ? r[24:22] : 0);
      end
      end_sim();
   end
endmodule // sbt_spi_burst_tb
`default_nettype wire
